// ===== logic/pds_if.sv
`timescale 1ns/1ns
interface pds_if;
  logic m_scl_i;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_i;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_scl_i;
  logic s_sda_i;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl_line;
  logic sda_line;

  // open-drain wires with pull-up: low whenever any enabled driver is low
  assign scl_line = !(!m_scl_oe_n && !m_scl_o);
  assign sda_line = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));
  assign m_scl_i = scl_line;
  assign m_sda_i = sda_line;
  assign s_scl_i = scl_line;
  assign s_sda_i = sda_line;

  modport master (
    input m_scl_i,
    output m_scl_o,
    output m_scl_oe_n,
    input m_sda_i,
    output m_sda_o,
    output m_sda_oe_n
  );

  modport slave (
    input s_scl_i,
    input s_sda_i,
    output s_sda_o,
    output s_sda_oe_n
  );
endinterface

// ===== logic/pds_master.sv
`timescale 1ns/1ns
module pds_master import pds_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_prot,
  input wire logic [2:0] cmd_chip,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  pds_if.master link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pds_mst_state_type st;
    logic [QTR_W-1:0] qcnt;
    logic [1:0] qph;
    logic [3:0] bit_cnt;
    logic [2:0] step;
    logic [7:0] shreg;
    logic scl_low;
    logic sda_low;
    logic nack;
    logic rd;
    logic prot;
    logic [2:0] chip;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rsp;
  } pds_mst_type;

  pds_mst_type cur_ff;
  pds_mst_type nxt_cur;
  logic sda_s;
  logic tick;
  logic [2:0] nstep;
  logic [7:0] sel_byte;

  pds_sync2 #(.WIDTH(1)) u_sda_sync (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(link.m_sda_i),
    .sync_out(sda_s)
  );

  // scl is this end's own, derived by dividing the system clock
  assign tick = (cur_ff.qcnt == QTR_W'(QTR_CYC - 1));
  assign sel_byte = {(cur_ff.prot ? TYPE_PROT : TYPE_MEM), cur_ff.chip, RW_WRITE};
  assign nstep = cur_ff.step + 3'h1;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rsp = 1'b0;
    if (cur_ff.st != MST_IDLE) begin
      nxt_cur.qcnt = tick ? '0 : cur_ff.qcnt + QTR_W'(1);
    end

    if (cur_ff.st == MST_IDLE) begin
      nxt_cur.scl_low = 1'b0;
      nxt_cur.sda_low = 1'b0;
      if (cmd_valid) begin
        nxt_cur.st = MST_START;
        nxt_cur.qcnt = '0;
        nxt_cur.qph = 2'h0;
        nxt_cur.step = STEP_START;
        nxt_cur.nack = 1'b0;
        nxt_cur.rd = cmd_read;
        nxt_cur.prot = cmd_prot;
        nxt_cur.chip = cmd_chip;
        nxt_cur.addr = cmd_addr;
        nxt_cur.wdata = cmd_wdata;
      end
    end else if (tick) begin
      nxt_cur.qph = cur_ff.qph + 2'h1;
      unique case (cur_ff.qph)
        2'h0: nxt_cur.scl_low = 1'b0;
        2'h1: begin
          // sda moves with scl high only to frame
          if (cur_ff.st == MST_START) begin
            nxt_cur.sda_low = 1'b1;
          end else if (cur_ff.st == MST_STOP) begin
            nxt_cur.sda_low = 1'b0;
          end else if (cur_ff.st == MST_SEND && cur_ff.bit_cnt == BITS_PER_BYTE) begin
            nxt_cur.nack = sda_s;
          end else if (cur_ff.st == MST_RECV && cur_ff.bit_cnt < BITS_PER_BYTE) begin
            nxt_cur.rdata = {cur_ff.rdata[6:0], sda_s};
          end
        end
        // no clock pulse after a stop: the bus must look idle
        2'h2: nxt_cur.scl_low = (cur_ff.st != MST_STOP);
        2'h3: begin
          nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
          if ((cur_ff.st == MST_SEND || cur_ff.st == MST_RECV) && cur_ff.bit_cnt < BITS_PER_BYTE) begin
            nxt_cur.shreg = {cur_ff.shreg[6:0], 1'b0};
            nxt_cur.sda_low = (cur_ff.st == MST_SEND) && (cur_ff.bit_cnt < 4'h7) && !cur_ff.shreg[6];
          end else if (cur_ff.st == MST_STOP) begin
            nxt_cur.st = MST_IDLE;
            nxt_cur.rsp = 1'b1;
          end else if (cur_ff.nack || cur_ff.st == MST_RECV) begin
            nxt_cur.st = MST_STOP;
            nxt_cur.sda_low = 1'b1;
          end else begin
            nxt_cur.step = nstep;
            nxt_cur.bit_cnt = 4'h0;
            nxt_cur.st = MST_SEND;
            unique case (nstep)
              STEP_SEL_W: nxt_cur.shreg = sel_byte;
              STEP_ADDR: nxt_cur.shreg = cur_ff.addr;
              STEP_DATA_OR_RESTART: nxt_cur.shreg = cur_ff.rd ? 8'h00 : cur_ff.wdata;
              STEP_SEL_R: nxt_cur.shreg = {sel_byte[7:1], RW_READ};
              default: nxt_cur.shreg = 8'h00;
            endcase
            if (nstep == STEP_DATA_OR_RESTART && cur_ff.rd) begin
              nxt_cur.st = MST_START;
            end else if (nstep == STEP_RECV) begin
              nxt_cur.st = MST_RECV;
            end else if (nstep > STEP_DATA_OR_RESTART && !cur_ff.rd) begin
              nxt_cur.st = MST_STOP;
            end
            // data for the next symbol settles while scl is low
            unique case (nxt_cur.st)
              MST_SEND: nxt_cur.sda_low = !nxt_cur.shreg[7];
              MST_STOP: nxt_cur.sda_low = 1'b1;
              default: nxt_cur.sda_low = 1'b0;
            endcase
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      cur_ff <= '0;
      cur_ff.st <= MST_IDLE;
    end else if (clk_en) begin
      cur_ff <= nxt_cur;
    end
  end

  assign cmd_ready = (cur_ff.st == MST_IDLE);
  assign rsp_valid = cur_ff.rsp;
  assign rsp_data = cur_ff.rdata;
  assign rsp_nack = cur_ff.nack;
  assign link.m_scl_o = 1'b0;
  assign link.m_scl_oe_n = !cur_ff.scl_low;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe_n = !cur_ff.sda_low;

endmodule

// ===== logic/pds_pkg.sv
package pds_pkg;

  // ---------------------------------------------------------------
  // clocking and link timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int SCL_KHZ = 400;
  // quarter of an scl period, least time so rounded up
  localparam int QTR_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam int INTERNAL_PROGRAM_TIME_MS = 10;
  // longest time, a whole number of cycles, so no rounding
  localparam int PROG_CYC = INTERNAL_PROGRAM_TIME_MS * CLK_KHZ;
  localparam int PROG_W = 20;
  localparam int QTR_W = 6;

  // ---------------------------------------------------------------
  // select byte layout
  // ---------------------------------------------------------------
  localparam int SEL_TYPE_HI = 7;
  localparam int SEL_TYPE_LO = 4;
  localparam int SEL_CHIP_HI = 3;
  localparam int SEL_CHIP_LO = 1;
  localparam int SEL_RW_BIT = 0;
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_PROT = 4'h6;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // ---------------------------------------------------------------
  // byte framing and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int MEM_DEPTH = 256;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [2:0] STEP_START = 3'h0;
  localparam logic [2:0] STEP_SEL_W = 3'h1;
  localparam logic [2:0] STEP_ADDR = 3'h2;
  localparam logic [2:0] STEP_DATA_OR_RESTART = 3'h3;
  localparam logic [2:0] STEP_SEL_R = 3'h4;
  localparam logic [2:0] STEP_RECV = 3'h5;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SLV_STANDBY, SLV_RX, SLV_ACK, SLV_TX, SLV_TX_ACK, SLV_WAIT_STOP, SLV_PROGRAM
  } pds_slv_state_type;

  typedef enum logic [1:0] {
    PH_SELECT, PH_ADDR, PH_DATA
  } pds_phase_type;

  typedef enum logic [2:0] {
    MST_IDLE, MST_START, MST_SEND, MST_RECV, MST_STOP
  } pds_mst_state_type;

endpackage

// ===== logic/pds_slave.sv
`timescale 1ns/1ns
// Functional notes
// - data changes only while clock low
// - master opens each command with start
// - ignore everything until a start
// - master ends each exchange with stop
// - stop abandons transfer, enters standby, or the program cycle after a write
// - transmitter releases data after eight bits
// - receiver pulls data low on ninth clock
// - matching select byte is acknowledged, except during the program cycle
// - each written byte is acknowledged
// - send eight bits, then sample acknowledge
// - acknowledged read continues with next byte
// - missing acknowledge stops data, await stop
// - select byte msb first, type chip rw
// - type 1010 selects the memory array
// - type 0110 selects the protection register
// - deaf during program cycle after write
// - random read uses write then restart
module pds_slave import pds_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic addr_select_bit_zero,
  input wire logic addr_select_bit_one,
  input wire logic addr_select_bit_two,
  output logic standby,
  output logic program_busy,
  pds_if.slave link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pds_slv_state_type st;
    pds_phase_type ph;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] prot;
    logic sel_prot;
    logic rd;
    logic wrote;
    logic ack_seen;
    logic drive_low;
    logic scl_prev;
    logic sda_prev;
    logic [PROG_W-1:0] prog_cnt;
  } pds_slv_type;

  pds_slv_type cur_ff;
  pds_slv_type nxt_cur;
  logic [7:0] mem [MEM_DEPTH];
  logic mem_we;
  logic [1:0] line_s;
  logic [2:0] strap_s;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic sel_match;
  logic [7:0] rd_byte;
  logic [7:0] nxt_ptr;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  pds_sync2 #(.WIDTH(2)) u_line_sync (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .async_in({link.s_scl_i, link.s_sda_i}),
    .sync_out(line_s)
  );

  pds_sync2 #(.WIDTH(3)) u_strap_sync (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .async_in({addr_select_bit_two, addr_select_bit_one, addr_select_bit_zero}),
    .sync_out(strap_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // ---------------------------------------------------------------
  // bus conditions
  // ---------------------------------------------------------------
  // data edge with clock high on both samples marks framing
  assign start_det = scl_s && cur_ff.scl_prev && cur_ff.sda_prev && !sda_s;
  assign stop_det = scl_s && cur_ff.scl_prev && !cur_ff.sda_prev && sda_s;
  assign scl_rise = scl_s && !cur_ff.scl_prev;
  assign scl_fall = !scl_s && cur_ff.scl_prev;

  // msb arrives first, so the byte sits whole in shreg after eight rises
  assign sel_match = (cur_ff.shreg[SEL_CHIP_HI:SEL_CHIP_LO] == strap_s) &&
    ((cur_ff.shreg[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_MEM) ||
     (cur_ff.shreg[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_PROT));

  assign rd_byte = cur_ff.sel_prot ? cur_ff.prot : mem[cur_ff.ptr];
  assign nxt_ptr = cur_ff.ptr + 8'h01;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    mem_we = 1'b0;
    nxt_cur.scl_prev = scl_s;
    nxt_cur.sda_prev = sda_s;

    unique case (cur_ff.st)
      SLV_STANDBY, SLV_WAIT_STOP: begin
        nxt_cur.drive_low = 1'b0;
      end

      SLV_RX: begin
        if (scl_rise && cur_ff.bit_cnt < BITS_PER_BYTE) begin
          nxt_cur.shreg = {cur_ff.shreg[6:0], sda_s};
          nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
        end else if (scl_fall && cur_ff.bit_cnt == BITS_PER_BYTE) begin
          nxt_cur.st = SLV_ACK;
          nxt_cur.drive_low = 1'b1;
          unique case (cur_ff.ph)
            PH_SELECT: begin
              if (sel_match) begin
                nxt_cur.rd = cur_ff.shreg[SEL_RW_BIT];
                nxt_cur.sel_prot = (cur_ff.shreg[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_PROT);
              end else begin
                // not ours: stay silent until the next frame
                nxt_cur.st = SLV_WAIT_STOP;
                nxt_cur.drive_low = 1'b0;
              end
            end
            PH_ADDR: begin
              nxt_cur.ptr = cur_ff.shreg;
            end
            PH_DATA: begin
              mem_we = !cur_ff.sel_prot;
              if (cur_ff.sel_prot) begin
                nxt_cur.prot = cur_ff.shreg;
              end
              nxt_cur.ptr = nxt_ptr;
              nxt_cur.wrote = 1'b1;
            end
            default: begin
              nxt_cur.st = SLV_WAIT_STOP;
              nxt_cur.drive_low = 1'b0;
            end
          endcase
        end
      end

      SLV_ACK: begin
        if (scl_fall) begin
          nxt_cur.bit_cnt = 4'h0;
          if (cur_ff.ph == PH_SELECT && cur_ff.rd == RW_READ) begin
            // first read bit goes out on the same falling edge
            nxt_cur.st = SLV_TX;
            nxt_cur.shreg = rd_byte;
            nxt_cur.drive_low = !rd_byte[7];
          end else begin
            nxt_cur.st = SLV_RX;
            nxt_cur.drive_low = 1'b0;
            nxt_cur.ph = (cur_ff.ph == PH_SELECT) ? PH_ADDR : PH_DATA;
          end
        end
      end

      SLV_TX: begin
        if (scl_rise) begin
          nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
        end else if (scl_fall) begin
          if (cur_ff.bit_cnt == BITS_PER_BYTE) begin
            nxt_cur.st = SLV_TX_ACK;
            nxt_cur.drive_low = 1'b0;
            nxt_cur.ptr = nxt_ptr;
          end else begin
            nxt_cur.shreg = {cur_ff.shreg[6:0], 1'b0};
            nxt_cur.drive_low = !cur_ff.shreg[6];
          end
        end
      end

      SLV_TX_ACK: begin
        if (scl_rise) begin
          nxt_cur.ack_seen = !sda_s;
        end else if (scl_fall) begin
          if (cur_ff.ack_seen) begin
            nxt_cur.st = SLV_TX;
            nxt_cur.bit_cnt = 4'h0;
            nxt_cur.shreg = rd_byte;
            nxt_cur.drive_low = !rd_byte[7];
          end else begin
            nxt_cur.st = SLV_WAIT_STOP;
          end
        end
      end

      SLV_PROGRAM: begin
        // bus interface off: line floats high, address not answered
        nxt_cur.drive_low = 1'b0;
        if (cur_ff.prog_cnt == '0) begin
          nxt_cur.st = SLV_STANDBY;
        end else begin
          nxt_cur.prog_cnt = cur_ff.prog_cnt - {{(PROG_W-1){1'b0}}, 1'b1};
        end
      end
    endcase

    // framing overrides every byte-level step except programming
    if (cur_ff.st != SLV_PROGRAM) begin
      if (start_det) begin
        nxt_cur.st = SLV_RX;
        nxt_cur.ph = PH_SELECT;
        nxt_cur.bit_cnt = 4'h0;
        nxt_cur.drive_low = 1'b0;
        mem_we = 1'b0;
      end else if (stop_det) begin
        nxt_cur.drive_low = 1'b0;
        nxt_cur.wrote = 1'b0;
        mem_we = 1'b0;
        if (cur_ff.wrote) begin
          nxt_cur.st = SLV_PROGRAM;
          nxt_cur.prog_cnt = PROG_CYCLES[PROG_W-1:0];
        end else begin
          nxt_cur.st = SLV_STANDBY;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      cur_ff.st <= SLV_STANDBY;
      cur_ff.ph <= PH_SELECT;
      cur_ff.bit_cnt <= 4'h0;
      cur_ff.shreg <= 8'h00;
      cur_ff.ptr <= PTR_RST;
      cur_ff.prot <= PROT_RST;
      cur_ff.sel_prot <= 1'b0;
      cur_ff.rd <= 1'b0;
      cur_ff.wrote <= 1'b0;
      cur_ff.ack_seen <= 1'b0;
      cur_ff.drive_low <= 1'b0;
      cur_ff.scl_prev <= 1'b1;
      cur_ff.sda_prev <= 1'b1;
      cur_ff.prog_cnt <= '0;
    end else if (clk_en) begin
      cur_ff <= nxt_cur;
    end
  end

  // array keeps contents across reset, as non-volatile storage would
  always_ff @(posedge clock) begin
    if (clk_en && mem_we) begin
      mem[cur_ff.ptr] <= cur_ff.shreg;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe_n = !cur_ff.drive_low;
  assign standby = (cur_ff.st == SLV_STANDBY);
  assign program_busy = (cur_ff.st == SLV_PROGRAM);

endmodule

// ===== logic/pds_sync2.sv
`timescale 1ns/1ns
module pds_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_ff <= '1;
      hold_ff <= '1;
    end else if (clk_en) begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;
endmodule

// ===== tb/pds_properties.sv
`timescale 1ns/1ns
module pds_properties (
  input wire logic clock,
  input wire logic srst,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n,
  input wire logic scl_line,
  input wire logic sda_line
);
  // ----------------------------------------
  // bus tracking
  // ----------------------------------------
  logic scl_q_ff, sda_q_ff, busy_ff, first_ff, rd_ff, sel_ok_ff, nack_ff;
  logic [3:0] bitn_ff;
  logic [12:0] busy_cnt_ff;
  logic start_p, stop_p, rise_p;
  assign start_p = scl_line && scl_q_ff && sda_q_ff && !sda_line;
  assign stop_p = scl_line && scl_q_ff && !sda_q_ff && sda_line;
  assign rise_p = scl_line && !scl_q_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      busy_ff <= 1'b0;
      first_ff <= 1'b0;
      rd_ff <= 1'b0;
      sel_ok_ff <= 1'b0;
      nack_ff <= 1'b0;
      bitn_ff <= 4'h0;
      busy_cnt_ff <= 13'h0;
    end else begin
      scl_q_ff <= scl_line;
      sda_q_ff <= sda_line;
      busy_cnt_ff <= busy_ff ? busy_cnt_ff + 13'h1 : 13'h0;
      if (start_p) begin
        busy_ff <= 1'b1;
        first_ff <= 1'b1;
        rd_ff <= 1'b0;
        sel_ok_ff <= 1'b0;
        nack_ff <= 1'b0;
        bitn_ff <= 4'h0;
      end else if (stop_p) begin
        busy_ff <= 1'b0;
        nack_ff <= 1'b0;
      end else if (rise_p) begin
        // ninth rise closes the byte; restart rises are undone by the start
        bitn_ff <= (bitn_ff == 4'h8) ? 4'h0 : bitn_ff + 4'h1;
        if (first_ff && bitn_ff == 4'h7) begin
          rd_ff <= sda_line;
        end
        if (bitn_ff == 4'h8) begin
          first_ff <= 1'b0;
          if (first_ff) begin
            sel_ok_ff <= !sda_line;
          end
          if (rd_ff && !first_ff && sda_line) begin
            nack_ff <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_slave_sda_stable: assert property ($changed(s_sda_oe_n) |-> !scl_line) else $error("slave sda moved, scl high");
  a_frame_opens: assert property ($fell(scl_line) |-> busy_ff) else $error("scl pulsed outside a frame");
  a_idle_quiet: assert property (!busy_ff |-> s_sda_oe_n) else $error("slave drives outside a frame");
  a_frame_ends: assert property (busy_cnt_ff < 13'h1b58) else $error("frame not closed by stop");
  a_stop_standby: assert property (stop_p |-> s_sda_oe_n [*8]) else $error("slave drives after stop");
  a_master_release: assert property (rise_p && bitn_ff == 4'h8 && (first_ff || !rd_ff) |-> m_sda_oe_n)
    else $error("master holds sda in ack slot");
  a_slave_release: assert property (rise_p && bitn_ff == 4'h8 && rd_ff && !first_ff |-> s_sda_oe_n)
    else $error("slave holds sda in ack slot");
  a_slave_slots: assert property (rise_p && !s_sda_oe_n |-> (bitn_ff == 4'h8) == (first_ff || !rd_ff))
    else $error("slave drives in wrong bit");
  a_write_acked: assert property (rise_p && bitn_ff == 4'h8 && !first_ff && !rd_ff && sel_ok_ff |-> !sda_line)
    else $error("written byte not acknowledged");
  a_nack_silent: assert property (nack_ff |-> s_sda_oe_n) else $error("slave sends after nack");
endmodule

// ===== tb/presence_detect_serial_slave_tb_top.sv
`timescale 1ns/1ns
module presence_detect_serial_slave_tb_top import pds_pkg::*;;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
  typedef struct packed {
    logic rd;
    logic prot;
    logic [2:0] chip;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic nack;
    logic [7:0] data;
  } pds_row_type;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic run = 1'b1;
  logic [2:0] strap = 3'h5;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_prot = 1'b0;
  logic [2:0] cmd_chip = 3'h0;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, standby, program_busy, standby_b, busy_b;
  logic [7:0] rsp_data;
  logic [8:0] got;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  pds_row_type rows [10] = '{
    '{1'h1, 1'h1, 3'h5, 8'h00, 8'h00, 1'h0, 8'h00}, '{1'h0, 1'h0, 3'h5, 8'h10, 8'ha5, 1'h0, 8'h00},
    '{1'h0, 1'h0, 3'h5, 8'hff, 8'h3c, 1'h0, 8'h00}, '{1'h0, 1'h0, 3'h2, 8'h10, 8'h00, 1'h1, 8'h00},
    '{1'h1, 1'h0, 3'h5, 8'h10, 8'h00, 1'h0, 8'ha5}, '{1'h1, 1'h0, 3'h5, 8'hff, 8'h00, 1'h0, 8'h3c},
    '{1'h0, 1'h1, 3'h5, 8'h00, 8'h5a, 1'h0, 8'h00}, '{1'h1, 1'h1, 3'h5, 8'h00, 8'h00, 1'h0, 8'h5a},
    '{1'h1, 1'h0, 3'h5, 8'h10, 8'h00, 1'h0, 8'ha5}, '{1'h1, 1'h0, 3'h4, 8'h10, 8'h00, 1'h1, 8'h00}};
  pds_if link();
  pds_if link2();
  pds_master u_pds_master (.clock(clock), .srst(srst), .clk_en(run), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_prot(cmd_prot), .cmd_chip(cmd_chip), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .link(link.master));
  // long program time shortened so the deaf window stays cheap to simulate
  pds_slave #(.PROG_CYCLES(2000)) u_pds_slave (.clock(clock), .srst(srst), .clk_en(run),
    .addr_select_bit_zero(strap[0]), .addr_select_bit_one(strap[1]), .addr_select_bit_two(strap[2]),
    .standby(standby), .program_busy(program_busy), .link(link.slave));
  pds_slave #(.PROG_CYCLES(2000)) u_pds_slave_2 (.clock(clock), .srst(srst), .clk_en(run),
    .addr_select_bit_zero(strap[0]), .addr_select_bit_one(strap[1]), .addr_select_bit_two(strap[2]),
    .standby(standby_b), .program_busy(busy_b), .link(link2.slave));
  pds_properties u_pds_properties (.clock(clock), .srst(srst), .m_sda_oe_n(link.m_sda_oe_n),
    .s_sda_oe_n(link.s_sda_oe_n), .scl_line(link.scl_line), .sda_line(link.sda_line));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      bad_count++;
      end_sim();
    end
  end
  task end_sim();
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task idle_wait();
    int n;
    n = 0;
    while (program_busy !== 1'b0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task run_cmd(input pds_row_type r);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 8000) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_read <= r.rd;
    cmd_prot <= r.prot;
    cmd_chip <= r.chip;
    cmd_addr <= r.addr;
    cmd_wdata <= r.wdata;
    @(posedge clock);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 8000);
    `CHK(rsp_nack, r.nack)
    if (r.rd && !r.nack) `CHK(rsp_data, r.data)
  endtask
  // bench as a bit-level master on the second link; data set while scl low
  task bb_bit(input logic b, output logic seen);
    @(posedge clock);
    link2.m_sda_oe_n <= b;
    repeat (32) @(posedge clock);
    link2.m_scl_oe_n <= 1'b1;
    repeat (16) @(negedge clock);
    seen = link2.sda_line;
    repeat (16) @(posedge clock);
    link2.m_scl_oe_n <= 1'b0;
  endtask
  // lowest bit is the bench's own ninth-clock level: 0 acknowledges
  task bb_byte(input logic [8:0] v, output logic [8:0] res);
    for (int i = 8; i >= 0; i--) bb_bit(v[i], res[i]);
  endtask
  task bb_cond(input logic is_start);
    @(posedge clock);
    link2.m_sda_oe_n <= is_start;
    repeat (32) @(posedge clock);
    link2.m_scl_oe_n <= 1'b1;
    repeat (32) @(posedge clock);
    link2.m_sda_oe_n <= !is_start;
    repeat (32) @(posedge clock);
    if (is_start) link2.m_scl_oe_n <= 1'b0;
    repeat (32) @(posedge clock);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    link2.m_scl_o = 1'b0;
    link2.m_sda_o = 1'b0;
    link2.m_scl_oe_n = 1'b1;
    link2.m_sda_oe_n = 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    `CHK({cmd_ready, rsp_valid, rsp_nack, rsp_data}, 11'h400)
    `CHK({standby, program_busy, link.scl_line, link.sda_line}, 4'hb)
    for (int i = 0; i < 10; i++) begin
      idle_wait();
      run_cmd(rows[i]);
    end
    // new straps; write then an immediate second write lands in the deaf window
    @(posedge clock);
    strap <= 3'h3;
    idle_wait();
    run_cmd('{1'h0, 1'h0, 3'h3, 8'h20, 8'h11, 1'h0, 8'h00});
    `CHK(program_busy, 1'b1)
    run_cmd('{1'h0, 1'h0, 3'h3, 8'h20, 8'h22, 1'h1, 8'h00});
    idle_wait();
    `CHK(standby, 1'b1)
    run_cmd('{1'h1, 1'h0, 3'h3, 8'h20, 8'h00, 1'h0, 8'h11});
    @(posedge clock);
    link2.m_scl_oe_n <= 1'b0;
    bb_byte({8'ha6, 1'b1}, got);
    `CHK(got[0], 1'b1)
    bb_cond(1'b1);
    bb_byte({8'ha6, 1'b1}, got);
    `CHK(got[0], 1'b0)
    `CHK(standby_b, 1'b0)
    bb_byte({8'h30, 1'b1}, got);
    `CHK(got[0], 1'b0)
    bb_cond(1'b0);
    repeat (8) @(negedge clock);
    `CHK({standby_b, busy_b}, 2'h2)
    bb_cond(1'b1);
    bb_byte({8'h67, 1'b1}, got);
    `CHK(got[0], 1'b0)
    bb_byte({8'hff, 1'b0}, got);
    `CHK(got, 9'h000)
    bb_byte({8'hff, 1'b1}, got);
    `CHK(got, 9'h001)
    bb_byte({8'hff, 1'b1}, got);
    `CHK(got, 9'h1ff)
    bb_cond(1'b0);
    `CHK({link.scl_line, link.sda_line, link2.scl_line, link2.sda_line}, 4'hf)
    end_sim();
  end
endmodule
